/* rtl/atp_ctrl.sv */
// Purpose: sleep mode control and output test pattern generation
// Assumes: serial port write-only, msb first, sampled on rising sclk
// Notes: sclk only runs inside frames, sdenb high clears the frame counter
//
// Overview of operation
// - master picks one of four sleep modes
// - low enable pin enters sleep, high leaves
// - operational after mode specific wake-up time
// - fixed zero and ones patterns from registers
// - aaa and 555 alternating pattern
// - fff and 000 alternating pattern
// - custom pattern word layout in registers
`timescale 1ns/1ns
module atp_ctrl
   import atp_pkg::*;
#(
   parameter int SHUTDOWN_CYC = WAKE_SHUTDOWN_CYC,
   parameter int STANDBY_CYC = WAKE_STANDBY_CYC,
   parameter int DATA_W = 12
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic sclk,
   input wire logic sdenb,
   input wire logic sdio,
   input wire logic enable_pin,
   input wire logic [DATA_W-1:0] sample_a,
   input wire logic [DATA_W-1:0] sample_b,
   output logic [DATA_W-1:0] data_a_ff,
   output logic [DATA_W-1:0] data_b_ff,
   output logic pattern_active_ff,
   output logic sleeping_ff,
   output logic ready_ff,
   output logic [1:0] power_mode_ff
);
   // serial link domain
   logic [4:0] bit_cnt_ff;
   logic [4:0] nxt_bit_cnt;
   logic [22:0] shift_ff;
   logic [22:0] nxt_shift;
   logic frame_done_ff;
   logic nxt_frame_done;
   logic [23:0] hold_ff;
   logic [23:0] nxt_hold;

   always_comb begin
      nxt_bit_cnt = bit_cnt_ff;
      nxt_shift = shift_ff;
      nxt_frame_done = frame_done_ff;
      nxt_hold = hold_ff;
      if (bit_cnt_ff < 5'(FRAME_BITS)) begin
         nxt_shift = {shift_ff[21:0], sdio};
         nxt_bit_cnt = bit_cnt_ff + 5'h01;
         if (bit_cnt_ff == 5'(FRAME_BITS - 1)) begin
            nxt_hold = {shift_ff, sdio};
            nxt_frame_done = 1'b1;
         end
      end
   end

   // frame counter cleared while enable is high
   always_ff @(posedge sclk or posedge sdenb) begin
      if (sdenb) begin
         bit_cnt_ff <= 5'h00;
         shift_ff <= 23'h000000;
         frame_done_ff <= 1'b0;
      end else begin
         bit_cnt_ff <= nxt_bit_cnt;
         shift_ff <= nxt_shift;
         frame_done_ff <= nxt_frame_done;
      end
   end

   // holding word stays stable until the next frame completes
   always_ff @(posedge sclk) begin
      hold_ff <= nxt_hold;
   end

   // core domain synchronisers
   logic done_s1_ff;
   logic done_s2_ff;
   logic done_s3_ff;
   logic en_s1_ff;
   logic en_s2_ff;

   always_ff @(posedge clock) begin
      if (rst) begin
         done_s1_ff <= 1'b0;
         done_s2_ff <= 1'b0;
         done_s3_ff <= 1'b0;
         en_s1_ff <= 1'b1;
         en_s2_ff <= 1'b1;
      end else begin
         done_s1_ff <= frame_done_ff;
         done_s2_ff <= done_s1_ff;
         done_s3_ff <= done_s2_ff;
         en_s1_ff <= enable_pin;
         en_s2_ff <= en_s1_ff;
      end
   end

   logic wr_stb;
   logic [6:0] wr_addr;
   logic [15:0] wr_data;
   assign wr_stb = done_s2_ff & ~done_s3_ff & ~hold_ff[RW_BIT];
   assign wr_addr = hold_ff[22:16];
   assign wr_data = hold_ff[15:0];

   // register file
   logic [15:0] hp_ctrl_ff;
   logic [15:0] nxt_hp_ctrl;
   logic [1:0] nxt_power_mode;
   logic [15:0] pattern_select_word_ff;
   logic [15:0] nxt_pattern_select_word;
   logic [15:0] pattern_value_word_ff;
   logic [15:0] nxt_pattern_value_word;
   logic [15:0] pattern_aux_word_ff;
   logic [15:0] nxt_pattern_aux_word;

   always_comb begin
      nxt_hp_ctrl = hp_ctrl_ff;
      nxt_power_mode = power_mode_ff;
      nxt_pattern_select_word = pattern_select_word_ff;
      nxt_pattern_value_word = pattern_value_word_ff;
      nxt_pattern_aux_word = pattern_aux_word_ff;
      if (wr_stb && wr_addr == ADDR_HP_CTRL) begin
         nxt_hp_ctrl = wr_data;
      end else if (wr_stb && wr_addr == ADDR_POWER_MODE) begin
         nxt_power_mode = wr_data[PWR_MODE_LSB+1:PWR_MODE_LSB];
      end else if (wr_stb && wr_addr == ADDR_PAT_SELECT) begin
         nxt_pattern_select_word = wr_data;
      end else if (wr_stb && wr_addr == ADDR_PAT_VALUE) begin
         nxt_pattern_value_word = wr_data;
      end else if (wr_stb && wr_addr == ADDR_PAT_AUX) begin
         nxt_pattern_aux_word = wr_data;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         hp_ctrl_ff <= RST_HP_CTRL;
         power_mode_ff <= RST_POWER_MODE;
         pattern_select_word_ff <= RST_PAT;
         pattern_value_word_ff <= RST_PAT;
         pattern_aux_word_ff <= RST_PAT;
      end else begin
         hp_ctrl_ff <= nxt_hp_ctrl;
         power_mode_ff <= nxt_power_mode;
         pattern_select_word_ff <= nxt_pattern_select_word;
         pattern_value_word_ff <= nxt_pattern_value_word;
         pattern_aux_word_ff <= nxt_pattern_aux_word;
      end
   end

   // sleep and wake sequencing
   atp_state_type state_ff;
   atp_state_type nxt_state;
   logic [WAKE_CNT_W-1:0] wake_cnt_ff;
   logic [WAKE_CNT_W-1:0] nxt_wake_cnt;
   logic [1:0] sleep_mode_ff;
   logic [1:0] nxt_sleep_mode;
   logic nxt_sleeping;
   logic nxt_ready;
   logic [WAKE_CNT_W-1:0] wake_load;

   always_comb begin
      case (atp_pmode_type'(sleep_mode_ff))
         PM_SHUTDOWN: wake_load = WAKE_CNT_W'(SHUTDOWN_CYC);
         PM_STANDBY: wake_load = WAKE_CNT_W'(STANDBY_CYC);
         PM_DEEP: wake_load = WAKE_CNT_W'(WAKE_DEEP_CYC);
         default: wake_load = WAKE_CNT_W'(WAKE_LIGHT_CYC);
      endcase
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_wake_cnt = wake_cnt_ff;
      nxt_sleep_mode = sleep_mode_ff;
      case (state_ff)
         ST_RUN: begin
            if (!en_s2_ff) begin
               nxt_state = ST_SLEEP;
               nxt_sleep_mode = power_mode_ff;
            end
         end
         ST_SLEEP: begin
            if (en_s2_ff) begin
               nxt_state = ST_WAKE;
               nxt_wake_cnt = wake_load - 18'h00001;
            end
         end
         ST_WAKE: begin
            if (!en_s2_ff) begin
               nxt_state = ST_SLEEP;
            end else if (wake_cnt_ff == 18'h00000) begin
               nxt_state = ST_RUN;
            end else begin
               nxt_wake_cnt = wake_cnt_ff - 18'h00001;
            end
         end
         default: nxt_state = ST_RUN;
      endcase
      nxt_sleeping = (nxt_state == ST_SLEEP);
      nxt_ready = (nxt_state == ST_RUN);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff <= ST_RUN;
         wake_cnt_ff <= 18'h00000;
         sleep_mode_ff <= RST_POWER_MODE;
         sleeping_ff <= 1'b0;
         ready_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         wake_cnt_ff <= nxt_wake_cnt;
         sleep_mode_ff <= nxt_sleep_mode;
         sleeping_ff <= nxt_sleeping;
         ready_ff <= nxt_ready;
      end
   end

   // test pattern generation
   logic [DATA_W-1:0] sel_field;
   logic [DATA_W-1:0] val_field;
   logic [DATA_W-1:0] aux_field;
   logic pat_on;
   logic phase_ff;
   logic nxt_phase;
   logic [DATA_W-1:0] pat_word;
   logic [DATA_W-1:0] nxt_data_a;
   logic [DATA_W-1:0] nxt_data_b;

   assign sel_field = pattern_select_word_ff[PAT_WORD_MSB:PAT_WORD_LSB];
   assign val_field = pattern_value_word_ff[PAT_WORD_MSB:PAT_WORD_LSB];
   assign aux_field = pattern_aux_word_ff[PAT_WORD_MSB:PAT_WORD_LSB];
   assign pat_on = (pattern_select_word_ff[PAT_EN_MSB:PAT_EN_LSB] == PAT_EN_CODE)
                   && !hp_ctrl_ff[HIGH_PERF_MODE_ONE_BIT];

   always_comb begin
      nxt_phase = pat_on ? ~phase_ff : 1'b0;
      // nonzero select field alternates value and aux words
      if (sel_field != '0 && phase_ff) begin
         pat_word = aux_field;
      end else begin
         pat_word = val_field;
      end
      nxt_data_a = pat_on ? pat_word : sample_a;
      nxt_data_b = pat_on ? pat_word : sample_b;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         phase_ff <= 1'b0;
         data_a_ff <= '0;
         data_b_ff <= '0;
         pattern_active_ff <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
         data_a_ff <= nxt_data_a;
         data_b_ff <= nxt_data_b;
         pattern_active_ff <= pat_on;
      end
   end
endmodule

/* inc/atp_pkg.sv */
// Purpose: shared constants for the sleep and test pattern control block
// Assumes: core clock of 100 MHz, 7-bit address and 16-bit data serial frames
// Notes: times are held in ns, cycle counts derive from the clock period
package atp_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int WAKE_SHUTDOWN_NS = 2500000;
   localparam int WAKE_STANDBY_NS = 100000;
   localparam int WAKE_DEEP_NS = 20000;
   localparam int WAKE_LIGHT_NS = 2000;
   localparam int WAKE_SHUTDOWN_CYC = WAKE_SHUTDOWN_NS / CLK_PERIOD_NS;
   localparam int WAKE_STANDBY_CYC = WAKE_STANDBY_NS / CLK_PERIOD_NS;
   localparam int WAKE_DEEP_CYC = WAKE_DEEP_NS / CLK_PERIOD_NS;
   localparam int WAKE_LIGHT_CYC = WAKE_LIGHT_NS / CLK_PERIOD_NS;
   localparam int WAKE_CNT_W = 18;

   localparam logic [6:0] ADDR_HP_CTRL = 7'h01;
   localparam logic [6:0] ADDR_POWER_MODE = 7'h37;
   localparam logic [6:0] ADDR_PAT_SELECT = 7'h3C;
   localparam logic [6:0] ADDR_PAT_VALUE = 7'h3D;
   localparam logic [6:0] ADDR_PAT_AUX = 7'h3E;

   localparam int HIGH_PERF_MODE_ONE_BIT = 1;
   localparam int PWR_MODE_LSB = 0;
   localparam int PAT_EN_MSB = 15;
   localparam int PAT_EN_LSB = 14;
   localparam logic [1:0] PAT_EN_CODE = 2'h2;
   localparam int PAT_WORD_MSB = 13;
   localparam int PAT_WORD_LSB = 2;

   localparam logic [15:0] RST_HP_CTRL = 16'h0002;
   localparam logic [1:0] RST_POWER_MODE = 2'h0;
   localparam logic [15:0] RST_PAT = 16'h0000;

   localparam int FRAME_BITS = 24;
   localparam int RW_BIT = 23;

   typedef enum logic [1:0] {
      PM_SHUTDOWN = 2'b00,
      PM_STANDBY = 2'b01,
      PM_DEEP = 2'b10,
      PM_LIGHT = 2'b11
   } atp_pmode_type;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SLEEP = 2'b01,
      ST_WAKE = 2'b10
   } atp_state_type;
endpackage

/* verif/atp_ctrl_chk.sv */
// Purpose: port assertions for atp_ctrl
// Assumes: power mode is not rewritten between sleep entry and ready
// Notes: bound at the foot of this file
`timescale 1ns/1ns
module atp_ctrl_chk
   import atp_pkg::*;
#(
   parameter int SHUTDOWN_CYC = WAKE_SHUTDOWN_CYC,
   parameter int STANDBY_CYC = WAKE_STANDBY_CYC,
   parameter int DATA_W = 12
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic enable_pin,
   input wire logic [DATA_W-1:0] sample_a,
   input wire logic [DATA_W-1:0] sample_b,
   input wire logic [DATA_W-1:0] data_a_ff,
   input wire logic [DATA_W-1:0] data_b_ff,
   input wire logic pattern_active_ff,
   input wire logic sleeping_ff,
   input wire logic ready_ff,
   input wire logic [1:0] power_mode_ff
);
   logic [19:0] wait_ff;
   logic [19:0] nxt_wait;
   int lim;
   // cycles spent waking, compared with the mode's wake time
   always_comb begin
      nxt_wait = (sleeping_ff || ready_ff) ? 20'h0 : wait_ff + 20'h1;
      case (power_mode_ff)
         2'h0: lim = SHUTDOWN_CYC;
         2'h1: lim = STANDBY_CYC;
         2'h2: lim = WAKE_DEEP_CYC;
         default: lim = WAKE_LIGHT_CYC;
      endcase
   end
   always_ff @(posedge clock) begin
      wait_ff <= rst ? 20'h0 : nxt_wait;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_reset_state: assert property (disable iff (1'b0) rst |=> ready_ff && !sleeping_ff && !pattern_active_ff
      && power_mode_ff == 2'h0 && data_a_ff == '0) else $error("outputs wrong after reset");
   a_sample_pass: assert property (!pattern_active_ff && !$past(pattern_active_ff) && !$past(rst)
      |-> data_a_ff == $past(sample_a)) else $error("sample not passed");
   a_sample_pass_b: assert property (!pattern_active_ff && !$past(rst)
      |-> data_b_ff == $past(sample_b)) else $error("sample b not passed");
   a_lanes_equal: assert property (pattern_active_ff |-> data_a_ff == data_b_ff)
      else $error("lanes differ");
   a_pattern_period: assert property (pattern_active_ff && $past(pattern_active_ff) && $past(pattern_active_ff, 2)
      |-> data_a_ff == $past(data_a_ff, 2)) else $error("pattern not periodic");
   a_sleep_entry: assert property ($fell(enable_pin) |-> ##[1:4] sleeping_ff)
      else $error("sleep not entered");
   a_sleep_exit: assert property ($rose(enable_pin) |-> ##[1:4] !sleeping_ff)
      else $error("sleep not left");
   a_sleep_cause: assert property ($rose(sleeping_ff) |-> !$past(enable_pin, 3))
      else $error("sleep without low pin");
   a_sleep_notready: assert property (sleeping_ff |-> !ready_ff) else $error("ready while asleep");
   a_wake_time: assert property ($rose(ready_ff) && !$past(rst) |-> wait_ff >= lim - 2 && wait_ff <= lim + 2)
      else $error("wake time wrong");
   a_wake_bound: assert property (wait_ff <= lim + 2) else $error("wake too long");
   c_ready: cover property ($rose(ready_ff) && power_mode_ff == 2'h0);
   c_toggle: cover property (pattern_active_ff && data_a_ff != $past(data_a_ff));
   c_sleep: cover property ($rose(sleeping_ff));
endmodule
bind atp_ctrl atp_ctrl_chk #(.SHUTDOWN_CYC(SHUTDOWN_CYC), .STANDBY_CYC(STANDBY_CYC), .DATA_W(DATA_W))
   atp_ctrl_chk_inst (.clock(clock), .rst(rst), .enable_pin(enable_pin), .sample_a(sample_a), .sample_b(sample_b),
   .data_a_ff(data_a_ff), .data_b_ff(data_b_ff), .pattern_active_ff(pattern_active_ff),
   .sleeping_ff(sleeping_ff), .ready_ff(ready_ff), .power_mode_ff(power_mode_ff));

/* verif/atp_cfg_master.sv */
// Purpose: serial configuration master model
// Assumes: 64 ns serial period, msb first
// Notes: sclk idles low, sdio inverted once released
`timescale 1ns/1ns
module atp_cfg_master (
   output logic sclk,
   output logic sdenb,
   output logic sdio
);
   initial begin
      sclk = 1'b0;
      sdenb = 1'b0;
      sdio = 1'b0;
      // rising enable clears the link side frame counter
      #1 sdenb = 1'b1;
   end
   task automatic wr(input logic [6:0] adr, input logic [15:0] dat, input logic rd);
      logic [23:0] f;
      f = {rd, adr, dat};
      #7 sdenb = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdio = f[i];
         #32 sclk = 1'b1;
         #32 sclk = 1'b0;
      end
      #25 sdenb = 1'b1;
      sdio = ~sdio;
      #100;
   endtask
endmodule

/* verif/tb_atp_ctrl.sv */
// Purpose: self-checking bench for atp_ctrl
// Assumes: wake counts shortened to 40 and 20 cycles
// Notes: inputs driven on the falling clock edge
`timescale 1ns/1ns
module tb_atp_ctrl;
   import atp_pkg::*;
   logic clock = 1'b0, rst = 1'b1, enable_pin = 1'b1, pchk = 1'b0;
   logic [11:0] sample_a = 12'h0, sample_b = 12'h0, data_a_ff, data_b_ff, w0, e0, e1;
   logic pattern_active_ff, sleeping_ff, ready_ff;
   logic [1:0] power_mode_ff;
   wire sclk, sdenb, sdio;
   int seed = 32'h39587DD2, bad_count = 0, comparisons = 0, n;
   int lims[4] = '{40, 20, WAKE_DEEP_CYC, WAKE_LIGHT_CYC};
   // select, value, aux, two expected words
   logic [15:0] tv[5][5] = '{'{16'h8000, 16'h0000, 16'h0000, 16'h000, 16'h000},
      '{16'hBFFC, 16'h3FFC, 16'h3FFC, 16'hFFF, 16'hFFF}, '{16'h9554, 16'h2AA8, 16'h1554, 16'hAAA, 16'h555},
      '{16'hBFFC, 16'h0000, 16'h3FFC, 16'h000, 16'hFFF}, '{16'h8000, 16'h0000, 16'h0000, 16'h000, 16'h000}};
   always #5 clock = ~clock;
   atp_ctrl #(.SHUTDOWN_CYC(40), .STANDBY_CYC(20)) atp_ctrl_inst (.clock(clock), .rst(rst), .sclk(sclk),
      .sdenb(sdenb), .sdio(sdio), .enable_pin(enable_pin), .sample_a(sample_a), .sample_b(sample_b),
      .data_a_ff(data_a_ff), .data_b_ff(data_b_ff), .pattern_active_ff(pattern_active_ff),
      .sleeping_ff(sleeping_ff), .ready_ff(ready_ff), .power_mode_ff(power_mode_ff));
   atp_cfg_master atp_cfg_master_inst (.sclk(sclk), .sdenb(sdenb), .sdio(sdio));
   task chk_w(input logic [11:0] got, input logic [11:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected word %h, wanted %h at %0t", got, exp, $time);
      end
   endtask
   task chk_b(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected flag %b at %0t", got, $time);
      end
   endtask
   task conclude;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // expected word in the cycle after one showing w
   function logic [11:0] next_word(input logic [11:0] w, input logic [11:0] a, input logic [11:0] b);
      return (w === a) ? b : a;
   endfunction
   always @(negedge clock) begin
      if (pchk) chk_w(data_a_ff, sample_a);
      if (pchk) chk_w(data_b_ff, sample_b);
      sample_a <= 12'($random(seed));
      sample_b <= 12'($random(seed));
   end
   initial begin
      repeat (20) @(posedge clock);
      @(negedge clock) rst = 1'b0;
      chk_b(ready_ff, 1'b1);
      chk_b(sleeping_ff, 1'b0);
      @(negedge clock) pchk = 1'b1;
      repeat (10) @(negedge clock);
      pchk = 1'b0;
      atp_cfg_master_inst.wr(7'h01, 16'h0000, 1'b0);
      w0 = 12'($random(seed));
      tv[4][1] = {2'b00, w0, 2'b00};
      tv[4][3] = {4'h0, w0};
      tv[4][4] = {4'h0, w0};
      for (int i = 0; i < 5; i++) begin
         atp_cfg_master_inst.wr(7'h3C, 16'h0000, 1'b0);
         atp_cfg_master_inst.wr(7'h3E, tv[i][2], 1'b0);
         atp_cfg_master_inst.wr(7'h3D, tv[i][1], 1'b0);
         atp_cfg_master_inst.wr(7'h3C, tv[i][0], 1'b0);
         @(negedge clock) chk_b(pattern_active_ff, 1'b1);
         e0 = tv[i][3][11:0];
         e1 = tv[i][4][11:0];
         w0 = data_a_ff;
         chk_w(w0, next_word(next_word(w0, e0, e1), e0, e1));
         @(negedge clock) chk_w(data_a_ff, next_word(w0, e0, e1));
      end
      atp_cfg_master_inst.wr(7'h01, 16'h0002, 1'b1);
      chk_b(pattern_active_ff, 1'b1);
      atp_cfg_master_inst.wr(7'h01, 16'h0002, 1'b0);
      chk_b(pattern_active_ff, 1'b0);
      for (int r = 0; r < 3; r++) atp_cfg_master_inst.wr(7'(8'h3C + r), 16'h0000, 1'b0);
      pchk = 1'b1;
      for (int m = 0; m < 4; m++) begin
         atp_cfg_master_inst.wr(7'h37, 16'(m), 1'b0);
         @(negedge clock) chk_w({10'h0, power_mode_ff}, 12'(m));
         enable_pin = 1'b0;
         for (n = 0; n < 10 && sleeping_ff !== 1'b1; n++) @(negedge clock);
         chk_b(ready_ff, 1'b0);
         if (n == 10) begin
            bad_count++;
            conclude;
         end
         repeat (30) @(negedge clock);
         enable_pin = 1'b1;
         for (n = 0; n < lims[m] + 50 && ready_ff !== 1'b1; n++) @(negedge clock);
         chk_b(n >= lims[m] && n <= lims[m] + 4, 1'b1);
         chk_b(sleeping_ff, 1'b0);
         if (n == lims[m] + 50) bad_count++;
         if (n == lims[m] + 50) conclude;
      end
      conclude;
   end
endmodule
